// ===== mhs_pkg.sv
// mhs_pkg: constants for the motion host exchange and strobe block.
// assumes a 125 MHz clock and a 32-bit classic wishbone slave port.
//
// Summary of operation
// - status words refreshed every position loop
// - averaged velocity published every 128 ms
// - host commands acted on within 4 ms
// - command bits start, abort, clear flags
// - word area lengths follow configured axis count
// - digital loops: 250 us, 1 ms, 2 ms
// - analog position loop by axis count
// - local logic takes one extra axis slot
// - analog torque axes get 0.5 ms velocity regulator
// - local logic sees data at position rate
// - control input: filter then position loop
// - strobe rising edge latches axis position
// - capture within 2 counts plus filter
// - captured position published within one loop
// - analog strobes pulled high when unconnected
package mhs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned SLOT_US     = 250;
  localparam int unsigned SLOT_CYC    = CLK_PER_US * SLOT_US;
  localparam int unsigned VEL_AVG_MS  = 128;
  localparam int unsigned VEL_SLOTS   = VEL_AVG_MS * 1000 / SLOT_US;
  localparam int unsigned CMD_LAT_MS  = 4;
  localparam int unsigned FLT24_US    = 5000;
  localparam int unsigned FLT24_CYC   = CLK_PER_US * FLT24_US;
  localparam int unsigned FLT5_US     = 10;
  localparam int unsigned FLT5_CYC    = CLK_PER_US * FLT5_US;
  localparam int unsigned VLOOP_US    = 1000;
  localparam int unsigned TQVEL_US    = 500;
  localparam int unsigned POS_A_US    = 500;
  localparam int unsigned POS_B_US    = 1000;
  localparam int unsigned POS_C_US    = 2000;
  localparam logic [3:0]  VLOOP_SL    = 4'(VLOOP_US / SLOT_US);
  localparam logic [3:0]  TQVEL_SL    = 4'(TQVEL_US / SLOT_US);
  localparam logic [3:0]  POS_A_SL    = 4'(POS_A_US / SLOT_US);
  localparam logic [3:0]  POS_B_SL    = 4'(POS_B_US / SLOT_US);
  localparam logic [3:0]  POS_C_SL    = 4'(POS_C_US / SLOT_US);
  localparam int unsigned IDX_W       = $clog2(VEL_SLOTS);
  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CFG      = 8'h00;
  localparam logic [7:0] REG_CMD      = 8'h04;
  localparam logic [7:0] REG_FLAGS    = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_AREA     = 8'h14;
  localparam logic [7:0] REG_CMD_DATA = 8'h18;
  localparam logic [7:0] REG_CMD_WORD = 8'h1C;
  localparam logic [3:0] BLK_POS      = 4'h4;
  localparam logic [3:0] BLK_VEL      = 4'h5;
  localparam logic [3:0] BLK_STRB     = 4'h6;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CFG_DIGITAL = 0;
  localparam int unsigned CFG_LLOGIC  = 1;
  localparam int unsigned CFG_AXES    = 2;
  localparam int unsigned CFG_TORQ    = 4;
  localparam int unsigned CFG_CTL24   = 8;
  localparam logic [8:0]  CFG_RST     = 9'h000;
  localparam logic [7:0]  STAT_WPA    = 8'h08;
  localparam logic [7:0]  CMD_WPA     = 8'h04;
  localparam int unsigned NAXES       = 4;
  localparam int unsigned NSTRB       = 2 * NAXES;
endpackage

// ===== mhs_core.sv
// mhs_core: host exchange, loop scheduler and strobe capture.
// assumes act_pos_i/act_vel_i come from servo logic on clk_i;
// strobe and control inputs are asynchronous pins.
module mhs_core
  import mhs_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = mhs_pkg::SLOT_CYC,
  parameter int unsigned CTL24_CYC   = mhs_pkg::FLT24_CYC
) (
  input  wire logic             clk_i,          // 125 MHz
  input  wire logic             reset_n_i,      // async, low
  input  wire logic             wb_cyc_i,       // bus cycle
  input  wire logic             wb_stb_i,       // bus strobe
  input  wire logic             wb_we_i,        // write
  input  wire logic [7:0]       wb_adr_i,       // byte address
  input  wire logic [3:0]       wb_sel_i,       // byte enables
  input  wire logic [31:0]      wb_dat_i,       // write data
  output logic      [31:0]      wb_dat_o,       // read data
  output logic                  wb_ack_o,       // acknowledge
  output logic                  irq_o,          // level interrupt
  input  wire logic [3:0][31:0] act_pos_i,      // actual positions
  input  wire logic [3:0][31:0] act_vel_i,      // averaged velocity
  input  wire logic [7:0]       strobe_i,       // two per axis
  input  wire logic [3:0]       ctl_i,          // faceplate controls
  output logic                  strobe_pu_en_o, // strobe pull-ups
  output logic                  cur_tick_o,     // current loop
  output logic                  vel_tick_o,     // velocity loop
  output logic                  pos_tick_o,     // position loop
  output logic                  logic_tick_o,   // local logic slot
  output logic      [3:0]       torq_tick_o,    // torque vel loops
  output logic      [3:0]       start_o,        // start motion
  output logic      [3:0]       abort_o,        // abort motion
  output logic      [3:0]       init_pos_o,     // init position
  output logic                  param_load_o,   // load parameter
  output logic      [1:0]       param_axis_o,   // parameter axis
  output logic      [3:0]       param_idx_o,    // parameter index
  output logic      [31:0]      cmd_data_o,     // command word data
  output logic      [3:0][31:0] strb_param_o,   // strobe operands
  output logic      [3:0]       ctl_level_o     // filtered controls
);
  import mhs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [23:0]       slot_cnt;
    logic [IDX_W-1:0]  slot_idx;
    logic              cur_tick;
    logic              vel_tick;
    logic              pos_tick;
    logic              logic_tick;
    logic              avg_tick;
    logic [3:0]        torq_tick;
    logic [8:0]        cfg;
    logic [7:0]        flags;
    logic [7:0]        irq_stat;
    logic [7:0]        irq_mask;
    logic [31:0]       cmd_data;
    logic [3:0]        start;
    logic [3:0]        abort;
    logic [3:0]        init_pos;
    logic              param_load;
    logic [1:0]        param_axis;
    logic [3:0]        param_idx;
    logic [3:0][31:0]  pos_snap;
    logic [3:0][31:0]  vel_snap;
    logic [3:0][31:0]  strb_cap;
    logic [3:0][31:0]  strb_pub;
    logic [7:0]        strb_s1;
    logic [7:0]        strb_s2;
    logic [7:0]        strb_s3;
    logic [7:0]        strb_lvl;
    logic [7:0]        strb_rise;
    logic [3:0]        ctl_s1;
    logic [3:0]        ctl_s2;
    logic [3:0]        ctl_s3;
    logic [3:0][19:0]  ctl_cnt;
    logic [3:0]        ctl_lvl;
    logic [3:0]        ctl_pub;
    logic              ack;
    logic [31:0]       dat;
  } mhs_state_t;

  mhs_state_t st_reg;
  mhs_state_t st_next;
  logic [7:0] clr_vec;
  logic [7:0] keep_vec;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge = m;
  endfunction

  // position loop length in slots
  function automatic logic [3:0] pos_slots(input logic [8:0] cfg);
    logic [1:0] ax;
    ax = cfg[CFG_AXES +: 2];
    if (cfg[CFG_DIGITAL]) begin
      pos_slots = POS_C_SL;
    end else if (cfg[CFG_LLOGIC]) begin
      pos_slots = (ax == 2'h0) ? POS_B_SL : POS_C_SL;
    end else begin
      case (ax)
        2'h0:    pos_slots = POS_A_SL;
        2'h1:    pos_slots = POS_B_SL;
        default: pos_slots = POS_C_SL;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic             slot_end;
    logic             ptick;
    logic [IDX_W-1:0] pmask;
    logic             req;
    logic             wr;
    logic [31:0]      wd;
    logic [7:0]       agree;
    logic [3:0]       cagree;
    logic [19:0]      lim;
    logic [2:0]       naxes;
    logic [1:0]       ax;
    slot_end = 1'b0;
    ptick    = 1'b0;
    pmask    = '0;
    req      = 1'b0;
    wr       = 1'b0;
    wd       = '0;
    agree    = '0;
    cagree   = '0;
    lim      = '0;
    naxes    = '0;
    ax       = '0;
    st_next  = st_reg;

    // slot scheduler
    slot_end = (st_reg.slot_cnt == 24'(SLOT_CYCLES - 1));
    st_next.slot_cnt = slot_end ? 24'h000000 : st_reg.slot_cnt + 24'h1;
    st_next.slot_idx = slot_end ? st_reg.slot_idx + 1'b1
                                : st_reg.slot_idx;
    pmask = IDX_W'(pos_slots(st_reg.cfg) - 4'h1);
    ptick = slot_end && ((st_reg.slot_idx & pmask) == '0);
    st_next.pos_tick = ptick;
    st_next.cur_tick = slot_end && st_reg.cfg[CFG_DIGITAL];
    st_next.vel_tick = slot_end && st_reg.cfg[CFG_DIGITAL]
      && ((st_reg.slot_idx & IDX_W'(VLOOP_SL - 4'h1)) == '0);
    st_next.logic_tick = ptick && st_reg.cfg[CFG_LLOGIC];
    st_next.avg_tick = slot_end && (st_reg.slot_idx == '0);
    naxes = {1'b0, st_reg.cfg[CFG_AXES +: 2]} + 3'h1;
    for (int a = 0; a < NAXES; a++) begin
      st_next.torq_tick[a] = slot_end && !st_reg.cfg[CFG_DIGITAL]
        && st_reg.cfg[CFG_TORQ + a] && (3'(a) < naxes)
        && ((st_reg.slot_idx & IDX_W'(TQVEL_SL - 4'h1)) == '0);
    end

    // status snapshots for the host and local logic
    if (ptick) begin
      st_next.pos_snap = act_pos_i;
      st_next.strb_pub = st_reg.strb_cap;
      st_next.ctl_pub  = st_reg.ctl_lvl;
    end
    // velocity is averaged upstream, so a slow publish is enough
    if (st_next.avg_tick) begin
      st_next.vel_snap = act_vel_i;
    end

    // strobes: a change counts once the 2nd and 3rd stages agree
    st_next.strb_s1 = strobe_i;
    st_next.strb_s2 = st_reg.strb_s1;
    st_next.strb_s3 = st_reg.strb_s2;
    agree = ~(st_reg.strb_s2 ^ st_reg.strb_s3);
    st_next.strb_lvl = (agree & st_reg.strb_s2)
                     | (~agree & st_reg.strb_lvl);
    st_next.strb_rise = st_next.strb_lvl & ~st_reg.strb_lvl;
    // capture on the edge cycle keeps the error to a few counts
    for (int a = 0; a < NAXES; a++) begin
      if (st_reg.strb_rise[2*a] || st_reg.strb_rise[2*a+1]) begin
        st_next.strb_cap[a] = act_pos_i[a];
      end
    end

    // control inputs: sync, then filter by voltage class
    st_next.ctl_s1 = ctl_i;
    st_next.ctl_s2 = st_reg.ctl_s1;
    st_next.ctl_s3 = st_reg.ctl_s2;
    cagree = ~(st_reg.ctl_s2 ^ st_reg.ctl_s3);
    lim = st_reg.cfg[CFG_CTL24] ? 20'(CTL24_CYC) : 20'(FLT5_CYC);
    for (int a = 0; a < NAXES; a++) begin
      if (!cagree[a] || st_reg.ctl_s2[a] == st_reg.ctl_lvl[a]) begin
        st_next.ctl_cnt[a] = 20'h00000;
      end else if (st_reg.ctl_cnt[a] >= lim - 20'h1) begin
        st_next.ctl_cnt[a] = 20'h00000;
        st_next.ctl_lvl[a] = st_reg.ctl_s2[a];
      end else begin
        st_next.ctl_cnt[a] = st_reg.ctl_cnt[a] + 20'h1;
      end
    end

    // wishbone: ack one cycle after request, write at the ack edge
    req = wb_cyc_i && wb_stb_i;
    st_next.ack = req && !st_reg.ack;
    wr = req && wb_we_i && st_reg.ack;
    wd = merge(32'h00000000, wb_dat_i, wb_sel_i);
    st_next.start      = 4'h0;
    st_next.abort      = 4'h0;
    st_next.init_pos   = 4'h0;
    st_next.param_load = 1'b0;
    clr_vec = 8'h00;
    if (wr && hit(wb_adr_i, REG_CMD)) begin
      st_next.start = wd[3:0];
      st_next.abort = wd[7:4];
      clr_vec       = wd[15:8];
    end
    if (wr && hit(wb_adr_i, REG_CFG)) begin
      st_next.cfg = 9'(merge({23'h0, st_reg.cfg}, wb_dat_i, wb_sel_i));
    end
    if (wr && hit(wb_adr_i, REG_IRQ_MASK)) begin
      st_next.irq_mask = wd[7:0];
    end
    if (wr && hit(wb_adr_i, REG_CMD_DATA)) begin
      st_next.cmd_data = merge(st_reg.cmd_data, wb_dat_i, wb_sel_i);
    end
    if (wr && hit(wb_adr_i, REG_CMD_WORD) && wb_sel_i[0]) begin
      ax = wb_dat_i[1:0];
      if (wb_dat_i[2]) begin
        st_next.param_load = 1'b1;
        st_next.param_axis = ax;
        st_next.param_idx  = wb_dat_i[7:4];
      end else begin
        st_next.init_pos[ax] = 1'b1;
      end
    end
    // a capture in the clearing cycle survives
    st_next.flags = (st_reg.flags & ~clr_vec) | st_reg.strb_rise;
    st_next.irq_stat = st_reg.irq_stat | st_reg.strb_rise;
    if (wr && hit(wb_adr_i, REG_IRQ_STAT)) begin
      st_next.irq_stat = (st_reg.irq_stat & ~wd[7:0])
                       | st_reg.strb_rise;
    end

    // read data
    if (req && !st_reg.ack && !wb_we_i) begin
      ax = wb_adr_i[3:2];
      st_next.dat = 32'h00000000;
      case (wb_adr_i[7:4])
        BLK_POS:  st_next.dat = st_reg.pos_snap[ax];
        BLK_VEL:  st_next.dat = st_reg.vel_snap[ax];
        BLK_STRB: st_next.dat = st_reg.strb_pub[ax];
        default: begin
          if (hit(wb_adr_i, REG_CFG)) begin
            st_next.dat = {23'h0, st_reg.cfg};
          end else if (hit(wb_adr_i, REG_FLAGS)) begin
            st_next.dat = {12'h0, st_reg.ctl_pub,
                           st_reg.strb_lvl, st_reg.flags};
          end else if (hit(wb_adr_i, REG_IRQ_STAT)) begin
            st_next.dat = {24'h0, st_reg.irq_stat};
          end else if (hit(wb_adr_i, REG_IRQ_MASK)) begin
            st_next.dat = {24'h0, st_reg.irq_mask};
          end else if (hit(wb_adr_i, REG_AREA)) begin
            st_next.dat = {16'h0, 8'(CMD_WPA * naxes),
                           8'(STAT_WPA * naxes)};
          end else if (hit(wb_adr_i, REG_CMD_DATA)) begin
            st_next.dat = st_reg.cmd_data;
          end
        end
      endcase
    end
  end

  assign keep_vec = st_reg.flags & ~clr_vec;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_dat_o       = st_reg.dat;
  assign wb_ack_o       = st_reg.ack;
  assign irq_o          = |(st_reg.irq_stat & st_reg.irq_mask);
  // pull-ups only in analog mode: open inputs then read high
  assign strobe_pu_en_o = !st_reg.cfg[CFG_DIGITAL];
  assign cur_tick_o     = st_reg.cur_tick;
  assign vel_tick_o     = st_reg.vel_tick;
  assign pos_tick_o     = st_reg.pos_tick;
  assign logic_tick_o   = st_reg.logic_tick;
  assign torq_tick_o    = st_reg.torq_tick;
  assign start_o        = st_reg.start;
  assign abort_o        = st_reg.abort;
  assign init_pos_o     = st_reg.init_pos;
  assign param_load_o   = st_reg.param_load;
  assign param_axis_o   = st_reg.param_axis;
  assign param_idx_o    = st_reg.param_idx;
  assign cmd_data_o     = st_reg.cmd_data;
  assign strb_param_o   = st_reg.strb_pub;
  assign ctl_level_o    = st_reg.ctl_pub;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence bus_ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence cmd_wr_s;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
      && hit(wb_adr_i, REG_CMD) && wb_sel_i[0];
  endsequence

  bus_ack_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("ack is not a single pulse after request");
  cmd_start_a: assert property (cmd_wr_s |=>
      start_o == $past(wb_dat_i[3:0]) ##1 start_o == 4'h0)
    else $error("start pulse does not follow command write");
  flag_set_a: assert property ((st_reg.strb_rise != 8'h00)
      |=> (st_reg.flags & $past(st_reg.strb_rise))
          == $past(st_reg.strb_rise))
    else $error("strobe flag not set after capture");
  flag_hold_a: assert property ((keep_vec != 8'h00)
      |=> (st_reg.flags & $past(keep_vec)) == $past(keep_vec))
    else $error("strobe flag lost without a clear");
  snap_a: assert property (pos_tick_o
      |-> st_reg.pos_snap == $past(act_pos_i))
    else $error("status not refreshed at position tick");
  strb_pub_a: assert property (pos_tick_o
      |-> strb_param_o == $past(st_reg.strb_cap))
    else $error("strobe position not published at tick");
  vel_slot_a: assert property (st_reg.avg_tick
      |-> st_reg.slot_idx == IDX_W'(1) && st_reg.slot_cnt == 24'h0)
    else $error("velocity publish off its slot");
  vel_hold_a: assert property (!st_reg.avg_tick
      |-> $stable(st_reg.vel_snap))
    else $error("velocity changed between publishes");
  torq_a: assert property (torq_tick_o[0]
      |-> !st_reg.cfg[CFG_DIGITAL] && st_reg.slot_idx[0])
    else $error("torque velocity tick off its period");
  cur_gap_a: assert property (cur_tick_o
      |=> !cur_tick_o [*8])
    else $error("current loop ticks too close");
  ctl_pub_a: assert property ($changed(ctl_level_o)
      |-> pos_tick_o)
    else $error("control level changed off the loop tick");
endmodule

// ===== mhs_host_model.sv
// mhs_host_model: host controller stand-in, a classic wishbone master.
// assumes a slave that acks each request; the bench calls xfer.
module mhs_host_model (
  input  wire logic        clk_i,    // bus clock
  input  wire logic        ack_i,    // slave acknowledge
  input  wire logic [31:0] rdat_i,   // slave read data
  output logic             cyc_o,    // bus cycle
  output logic             stb_o,    // bus strobe
  output logic             we_o,     // write
  output logic      [7:0]  adr_o,    // byte address
  output logic      [3:0]  sel_o,    // byte enables
  output logic      [31:0] dat_o     // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_o, stb_o, we_o, sel_o} = 7'h00;
    adr_o = 8'h00;
    dat_o = 32'h0000_0000;
  end

  // commands go out and status comes back one exchange at a time
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o} <= {2'b11, w, 4'hF};
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
    // released data lines must not keep showing the old word
    dat_o <= ~d;
  endtask
endmodule

// ===== mhs_core_test.sv
// mhs_core_test: register, scheduler and strobe tests of mhs_core.
// assumes the host model as bus master and short slot counts.
module mhs_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mhs_pkg::*;
  localparam int SC = 16;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc, stb, we, ack, irq, pu_en, cur_t, vel_t, pos_t, log_t, pload;
  logic [7:0] adr;
  logic [7:0] strobe = 8'h00;
  logic [3:0] sel, torq_t, start, abort, initp, pidx, ctl_lvl;
  logic [3:0] ctl = 4'h0;
  logic [1:0] paxis;
  logic [31:0] wdat, rdat, cdata;
  logic [3:0][31:0] pos_in = '0;
  logic [3:0][31:0] vel_in = '0;
  logic [3:0][31:0] sparam;
  int tests_run = 0;
  int fail_count = 0;
  int cycles = 0;
  int cf[10] = '{'h000, 'h004, 'h00C, 'h002, 'h006, 'h001, 'h001, 'h001,
                 'h01C, 'h002};
  int sg[10] = '{2, 2, 2, 2, 2, 2, 0, 1, 4, 3};
  int gs[10] = '{2, 4, 8, 4, 8, 8, 1, 4, 2, 4};

  always #4 clk_i = ~clk_i;

  mhs_host_model host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat));

  mhs_core #(.SLOT_CYCLES(SC), .CTL24_CYC(20)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .act_pos_i(pos_in),
    .act_vel_i(vel_in), .strobe_i(strobe), .ctl_i(ctl),
    .strobe_pu_en_o(pu_en), .cur_tick_o(cur_t), .vel_tick_o(vel_t),
    .pos_tick_o(pos_t), .logic_tick_o(log_t), .torq_tick_o(torq_t),
    .start_o(start), .abort_o(abort), .init_pos_o(initp),
    .param_load_o(pload), .param_axis_o(paxis), .param_idx_o(pidx),
    .cmd_data_o(cdata), .strb_param_o(sparam), .ctl_level_o(ctl_lvl));

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the longest test sequence
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  function automatic logic tk(input int w);
    case (w)
      0: return cur_t;
      1: return vel_t;
      2: return pos_t;
      3: return log_t;
      default: return torq_t[0];
    endcase
  endfunction

  // first gap after a config change may be partial, so skip it
  task automatic gap(input int w, input int exp);
    int n = 0;
    repeat (2) begin
      do @(posedge clk_i); while (tk(w) !== 1'b1);
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (tk(w) !== 1'b1);
    check(32'(n), 32'(exp));
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    int ax;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(REG_CFG, q);
    check(q, 32'(CFG_RST));
    rd(8'hF0, q);
    check(q, 32'h0000_0000);
    wr(REG_AREA, 32'h0000_FFFF);
    rd(REG_AREA, q);
    check(q, {16'h0000, CMD_WPA, STAT_WPA});
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      wr(REG_CFG, 32'(cf[i]));
      gap(sg[i], gs[i] * SC);
      ax = ((cf[i] >> 2) & 3) + 1;
      rd(REG_AREA, q);
      check(q, 32'(((CMD_WPA * ax) << 8) | (STAT_WPA * ax)));
      check(32'(pu_en), 32'(cf[i][0] == 0));
    end
    $display("test scheduler done");
    wr(REG_CMD, 32'h0000_0021);
    #1 check(32'({abort, start}), 32'h21);
    @(posedge clk_i);
    #1 check(32'({abort, start}), 32'h00);
    wr(REG_CMD_DATA, 32'hCAFE_0123);
    wr(REG_CMD_WORD, 32'h0000_0002);
    #1 check(32'(initp), 32'h4);
    wr(REG_CMD_WORD, 32'h0000_0055);
    #1 check(32'({pload, paxis, pidx}), 32'h55);
    check(cdata, 32'hCAFE_0123);
    rd(REG_CMD, q);
    check(q, 32'h0000_0000);
    $display("test commands done");
    wr(REG_CFG, 32'h0000_0000);
    pos_in[0] <= 32'h00AB_CDEF;
    @(posedge clk_i);
    strobe <= 8'h02;
    repeat (10) @(posedge clk_i);
    pos_in[0] <= 32'h0000_1111;
    strobe <= 8'h00;
    #1 check(32'(irq), 32'h0);
    rd(REG_FLAGS, q);
    // pin fall is still inside the synchroniser, so the level reads high
    check(q & 32'hFFFF, 32'h0202);
    wr(REG_IRQ_MASK, 32'h0000_0002);
    #1 check(32'(irq), 32'h1);
    repeat (2) begin
      do @(posedge clk_i); while (pos_t !== 1'b1);
    end
    rd({BLK_STRB, 4'h0}, q);
    check(q, 32'h00AB_CDEF);
    check(sparam[0], 32'h00AB_CDEF);
    rd({BLK_POS, 4'h0}, q);
    check(q, 32'h0000_1111);
    rd(REG_FLAGS, q);
    check(q & 32'hFFFF, 32'h0002);
    wr(REG_CMD, 32'h0000_0200);
    rd(REG_FLAGS, q);
    check(q & 32'hFF, 32'h00);
    wr(REG_IRQ_STAT, 32'h0000_0002);
    #1 check(32'(irq), 32'h0);
    $display("test strobe done");
    wr(REG_CFG, 32'h0000_0100);
    ctl <= 4'h5;
    repeat (8) @(posedge clk_i);
    #1 check(32'(ctl_lvl), 32'h0);
    repeat (80) @(posedge clk_i);
    #1 check(32'(ctl_lvl), 32'h5);
    // 5 V class: the long filter must hold the old level for a while
    wr(REG_CFG, 32'h0000_0000);
    ctl <= 4'h0;
    repeat (200) @(posedge clk_i);
    #1 check(32'(ctl_lvl), 32'h5);
    repeat (1200) @(posedge clk_i);
    #1 check(32'(ctl_lvl), 32'h0);
    $display("test control done");
    vel_in[0] <= 32'h0000_0777;
    do rd({BLK_VEL, 4'h0}, q); while (q !== 32'h0000_0777);
    vel_in[0] <= 32'h0000_0888;
    repeat (300) @(posedge clk_i);
    rd({BLK_VEL, 4'h0}, q);
    check(q, 32'h0000_0777);
    $display("test velocity done");
    final_report();
  end
endmodule
